/* rtl/dsid_defs.svh */
// Constants of the instruction decode and timing front end
//
// Function
// - Accept 24-bit program memory instruction words
// - Eight-bit opcode selects type, rest are operands
// - Exactly three opcodes span two words
// - Second word upper eight bits are zero
// - Lone second word executes as no-operation
// - Taken test or PC change adds NOP cycle
// - Branches, indirect, table, returns take extra cycles
// - Taken skip costs two or three cycles
// - Double moves and two-word instructions take two
// - Register form decodes base, source, destination
// - File form decodes address and destination select
// - Bit select from literal or base register
// - Literal arithmetic: base, literal, optional destination
// - Multiply class decodes accumulator, sources, prefetches, writeback
// - Writeback is pointer or its location plus two
// - Accumulator ops decode operand and shift amount
// - Bit select field is four bits, 0..15
// - File address covers zero to 0x1FFF
// - Ten-bit literal limited to 255 in byte mode
// - Program address literal LSB always zero
// - Ten-bit signed literal is two's complement
// - Width suffix byte, word, double; word default
// - Core keeps MCU and accumulator status flags
`ifndef DSID_DEFS_SVH
`define DSID_DEFS_SVH

// Opcode constants
`define DSID_OPC_NOP 8'h00
`define DSID_OPC_LGOTO 8'hE0
`define DSID_OPC_LCALL 8'hE1
`define DSID_OPC_LDO 8'hE2
// Register file offsets of the plain register port
`define DSID_REG_FLAGS 4'h0
`define DSID_REG_CTRL 4'h1
`define DSID_REG_ERR 4'h2
// Reset values
`define DSID_CTRL_RST 1'b1
`define DSID_FLAGS_RST 9'h000
// Literal limits and fixed registers
`define DSID_LIT_BYTE_MAX 10'h0FF
`define DSID_WBACK_PTR 4'hD
`define DSID_W4 4'h4
// Cycle counts
`define DSID_CYC_ONE 2'h1
`define DSID_CYC_TWO 2'h2
`define DSID_CYC_THREE 2'h3
// Flag update masks, accumulator flags high, core flags low
`define DSID_MASK_MCU 9'h01F
`define DSID_MASK_DSP 9'h1E0

`endif

/* rtl/dsid_pkg.sv */
// Types of the instruction decode and timing front end
package dsid_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SECOND = 2'b01,
        ST_STALL = 2'b10
    } dsid_state_t;

    // Instruction class, carried in opcode bits 7:4
    typedef enum logic [3:0] {
        CL_NOP = 4'b0000,
        CL_REG = 4'b0001,
        CL_FILE = 4'b0010,
        CL_BIT = 4'b0011,
        CL_LIT = 4'b0100,
        CL_MULACC = 4'b0101,
        CL_ACC = 4'b0110,
        CL_BRANCH = 4'b0111,
        CL_BRC = 4'b1000,
        CL_SKIP = 4'b1001,
        CL_IND = 4'b1010,
        CL_TBL = 4'b1011,
        CL_RET = 4'b1100,
        CL_DMOV = 4'b1101,
        CL_LONG = 4'b1110,
        CL_RSV = 4'b1111
    } dsid_class_t;

    // Operation width
    typedef enum logic [1:0] {
        WD_WORD = 2'b00,
        WD_BYTE = 2'b01,
        WD_DOUBLE = 2'b10
    } dsid_width_t;

    // Accumulator writeback destination
    typedef enum logic [1:0] {
        WBD_NONE = 2'b00,
        WBD_DIRECT = 2'b01,
        WBD_POSTINC = 2'b10
    } dsid_wbdest_t;

    // Decoded instruction
    typedef struct packed {
        dsid_class_t cls;
        logic [7:0] opcode;
        dsid_width_t width;
        logic [3:0] base;
        logic [3:0] src;
        logic [2:0] smode;
        logic [3:0] dst;
        logic [2:0] dmode;
        logic [12:0] faddr;
        logic to_wzero;
        logic [3:0] bitsel;
        logic bit_ind;
        logic [15:0] lit;
        logic lit_err;
        logic acc_b;
        logic [3:0] mula;
        logic [3:0] mulb;
        logic [3:0] xpf;
        logic [3:0] ypf;
        logic [1:0] xd;
        logic [1:0] yd;
        dsid_wbdest_t wbdest;
        logic [3:0] shreg;
        logic shby_reg;
        logic [22:0] paddr;
        logic addr_err;
    } dsid_dec_t;

    // Whole state of the decoder
    typedef struct packed {
        dsid_state_t st;
        logic [1:0] cnt;
        logic [23:0] first;
        logic en;
        logic [8:0] flags;
        logic [8:0] umask;
        logic [2:0] err;
        logic [15:0] rdata;
        logic valid;
        logic nop;
        logic [1:0] cycles;
        dsid_dec_t dec;
    } dsid_regs_t;

endpackage

/* rtl/dsid_decoder.sv */
// Instruction decode and cycle timing front end with status flags
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dsid_defs.svh"

module dsid_decoder (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Fetch side
    input wire logic fetch_valid_i,
    input wire logic [23:0] fetch_word_i,
    input wire logic [23:0] fetch_next_i,
    output logic fetch_ready_o,
    // Datapath condition and result flags
    input wire logic cond_true_i,
    input wire logic res_valid_i,
    input wire logic [8:0] res_flags_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Decoded instruction
    output logic dec_valid_o,
    output logic dec_nop_o,
    output logic [1:0] dec_cycles_o,
    output logic [3:0] dec_class_o,
    output logic [7:0] dec_opcode_o,
    output logic [1:0] dec_width_o,
    output logic [3:0] base_reg_operand_o,
    output logic [3:0] source_reg_operand_o,
    output logic [2:0] src_mode_o,
    output logic [3:0] dest_reg_operand_o,
    output logic [2:0] dst_mode_o,
    output logic [12:0] file_addr_o,
    output logic to_working_reg_zero_o,
    output logic [3:0] bit_select_field_o,
    output logic bit_indirect_o,
    output logic [15:0] literal_o,
    output logic acc_b_sel_o,
    output logic [3:0] mul_src_a_o,
    output logic [3:0] mul_src_b_o,
    output logic [3:0] x_prefetch_o,
    output logic [3:0] y_prefetch_o,
    output logic [1:0] x_dest_o,
    output logic [1:0] y_dest_o,
    output logic [1:0] acc_writeback_dest_o,
    output logic [3:0] shift_count_reg_o,
    output logic shift_by_reg_o,
    output logic [22:0] program_address_literal_o,
    // Status
    output logic [8:0] status_flags_o,
    output logic [2:0] error_o
);

    // Registered state and its next value
    dsid_pkg::dsid_regs_t r_q;
    dsid_pkg::dsid_regs_t r_d;
    // Fetch word accepted this cycle
    logic take;

    // One of the three two-word opcodes
    function automatic logic is_two_word(input logic [7:0] opc);
        is_two_word = (opc == `DSID_OPC_LGOTO) || (opc == `DSID_OPC_LCALL)
            || (opc == `DSID_OPC_LDO);
    endfunction

    // Cycle count of a single-word instruction
    function automatic logic [1:0] cycles_of(input dsid_pkg::dsid_class_t c,
        input logic cond, input logic [7:0] next_opc);
        case (c)
            dsid_pkg::CL_BRANCH, dsid_pkg::CL_IND, dsid_pkg::CL_TBL, dsid_pkg::CL_DMOV:
                cycles_of = `DSID_CYC_TWO;
            dsid_pkg::CL_RET: cycles_of = `DSID_CYC_THREE;
            dsid_pkg::CL_BRC: cycles_of = cond ? `DSID_CYC_TWO : `DSID_CYC_ONE;
            // Skipped instruction length sets the cost
            dsid_pkg::CL_SKIP: cycles_of = !cond ? `DSID_CYC_ONE
                : (is_two_word(next_opc) ? `DSID_CYC_THREE : `DSID_CYC_TWO);
            default: cycles_of = `DSID_CYC_ONE;
        endcase
    endfunction

    // Operand field split of one instruction; w2 is the second word
    function automatic dsid_pkg::dsid_dec_t decode(input logic [23:0] w, input logic [23:0] w2);
        dsid_pkg::dsid_dec_t d;
        logic [7:0] opc;
        d = '0;
        opc = w[23:16];
        d.opcode = opc;
        d.cls = dsid_pkg::dsid_class_t'(opc[7:4]);
        // Width: byte variant bit, double moves, word by default
        d.width = dsid_pkg::WD_WORD;
        if (d.cls == dsid_pkg::CL_DMOV)
            d.width = dsid_pkg::WD_DOUBLE;
        else if (opc[3] && (d.cls inside {dsid_pkg::CL_REG, dsid_pkg::CL_FILE, dsid_pkg::CL_LIT}))
            d.width = dsid_pkg::WD_BYTE;
        case (d.cls)
            // Base, moded source, moded destination
            dsid_pkg::CL_REG, dsid_pkg::CL_DMOV:
            begin
                d.smode = opc[2:0];
                d.base = w[15:12];
                d.src = w[11:8];
                d.dmode = w[7:5];
                d.dst = w[3:0];
            end
            // File address and destination select
            dsid_pkg::CL_FILE:
            begin
                d.faddr = w[12:0];
                d.to_wzero = w[13];
            end
            // Bit number from literal or base register
            dsid_pkg::CL_BIT:
            begin
                d.base = w[15:12];
                d.bit_ind = w[7];
                d.bitsel = w[7] ? 4'h0 : w[11:8];
                d.smode = w[6:4];
                d.src = w[3:0];
            end
            // Literal arithmetic, short form names its own destination
            dsid_pkg::CL_LIT:
            begin
                if (opc[2])
                begin
                    d.base = w[15:12];
                    d.dmode = w[11:9];
                    d.lit = {11'h000, w[8:4]};
                    d.dst = w[3:0];
                end
                else
                begin
                    d.base = w[3:0];
                    d.dst = w[3:0];
                    // Signed variant sign-extends, else zero-extends
                    d.lit = opc[1] ? {{6{w[13]}}, w[13:4]} : {6'h00, w[13:4]};
                    d.lit_err = !opc[1] && opc[3] && (w[13:4] > `DSID_LIT_BYTE_MAX);
                end
            end
            // Multiply class operand set
            dsid_pkg::CL_MULACC:
            begin
                d.acc_b = w[15];
                case (w[14:12])
                    3'h0: {d.mula, d.mulb} = {4'h4, 4'h5};
                    3'h1: {d.mula, d.mulb} = {4'h4, 4'h6};
                    3'h2: {d.mula, d.mulb} = {4'h4, 4'h7};
                    3'h3: {d.mula, d.mulb} = {4'h5, 4'h6};
                    3'h4: {d.mula, d.mulb} = {4'h5, 4'h7};
                    3'h5: {d.mula, d.mulb} = {4'h6, 4'h7};
                    3'h6: {d.mula, d.mulb} = {4'h4, 4'h4};
                    default: {d.mula, d.mulb} = {4'h5, 4'h5};
                endcase
                d.xd = w[11:10];
                d.yd = w[9:8];
                d.xpf = w[7:4];
                d.ypf = w[3:0];
                // Writeback through the fixed pointer register
                d.wbdest = dsid_pkg::dsid_wbdest_t'(opc[1:0]);
                d.base = (opc[1:0] == 2'b00) ? 4'h0 : `DSID_WBACK_PTR;
            end
            // Accumulator op without multiply
            dsid_pkg::CL_ACC:
            begin
                d.acc_b = w[15];
                d.shby_reg = w[14];
                d.shreg = w[14] ? w[13:10] : 4'h0;
                d.lit = w[14] ? 16'h0000 : {{10{w[13]}}, w[13:8]};
                d.smode = w[6:4];
                d.src = w[3:0];
            end
            // Two-word program address, low bit forced clear
            dsid_pkg::CL_LONG:
            begin
                d.paddr = {w2[6:0], w[15:1], 1'b0};
                d.addr_err = w[0];
            end
            default:
            begin
                d.src = w[3:0];
            end
        endcase
        // Reserved two-word-class codes and reserved-class codes do nothing
        if ((d.cls == dsid_pkg::CL_LONG && !is_two_word(opc)) || d.cls == dsid_pkg::CL_RSV)
            d = '0;
        decode = d;
    endfunction

    // Flag update mask by class
    function automatic logic [8:0] mask_of(input dsid_pkg::dsid_class_t c);
        case (c)
            dsid_pkg::CL_REG, dsid_pkg::CL_FILE, dsid_pkg::CL_LIT: mask_of = `DSID_MASK_MCU;
            dsid_pkg::CL_MULACC, dsid_pkg::CL_ACC: mask_of = `DSID_MASK_DSP;
            default: mask_of = 9'h000;
        endcase
    endfunction

    // Word accepted while not stalling
    assign take = fetch_valid_i && r_q.en && (r_q.st != dsid_pkg::ST_STALL);

    // Next-state logic
    always_comb
    begin
        r_d = r_q;
        r_d.valid = 1'b0;
        r_d.nop = 1'b0;
        r_d.rdata = 16'h0000;
        // Register reads answer next cycle, unmapped reads zero
        if (reg_rd_i)
        begin
            if (reg_addr_i == `DSID_REG_FLAGS)
                r_d.rdata = {7'h00, r_q.flags};
            else if (reg_addr_i == `DSID_REG_CTRL)
                r_d.rdata = {15'h0000, r_q.en};
            else if (reg_addr_i == `DSID_REG_ERR)
                r_d.rdata = {11'h000, r_q.cycles, r_q.err};
        end
        // Register writes; error bits clear on one
        if (reg_wr_i)
        begin
            if (reg_addr_i == `DSID_REG_FLAGS)
                r_d.flags = reg_wdata_i[8:0];
            else if (reg_addr_i == `DSID_REG_CTRL)
                r_d.en = reg_wdata_i[0];
            else if (reg_addr_i == `DSID_REG_ERR)
                r_d.err = r_q.err & ~reg_wdata_i[2:0];
        end
        // Datapath results update flags of the issuing class
        if (res_valid_i)
            r_d.flags = (r_d.flags & ~r_q.umask) | (res_flags_i & r_q.umask);
        case (r_q.st)
            // Decode a fresh word
            dsid_pkg::ST_RUN:
            begin
                if (take && is_two_word(fetch_word_i[23:16]))
                begin
                    r_d.first = fetch_word_i;
                    r_d.st = dsid_pkg::ST_SECOND;
                end
                else if (take)
                begin
                    r_d.dec = decode(fetch_word_i, 24'h000000);
                    r_d.valid = 1'b1;
                    r_d.cycles = cycles_of(r_d.dec.cls, cond_true_i, fetch_next_i[23:16]);
                    r_d.umask = mask_of(r_d.dec.cls);
                    r_d.err[0] = r_d.err[0] | r_d.dec.lit_err;
                    if (r_d.cycles != `DSID_CYC_ONE)
                    begin
                        r_d.cnt = r_d.cycles - 2'h1;
                        r_d.st = dsid_pkg::ST_STALL;
                    end
                end
            end
            // Join the second word and issue
            dsid_pkg::ST_SECOND:
            begin
                if (take)
                begin
                    r_d.dec = decode(r_q.first, fetch_word_i);
                    r_d.valid = 1'b1;
                    r_d.cycles = `DSID_CYC_TWO;
                    r_d.umask = 9'h000;
                    r_d.err[1] = r_d.err[1] | r_d.dec.addr_err;
                    r_d.err[2] = r_d.err[2] | (fetch_word_i[23:16] != 8'h00);
                    r_d.st = dsid_pkg::ST_RUN;
                end
            end
            // Inserted no-operation cycles
            dsid_pkg::ST_STALL:
            begin
                r_d.nop = 1'b1;
                r_d.cnt = r_q.cnt - 2'h1;
                if (r_q.cnt == 2'h1)
                    r_d.st = dsid_pkg::ST_RUN;
            end
            default:
            begin
                r_d.st = dsid_pkg::ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            r_q <= '0;
            r_q.en <= `DSID_CTRL_RST;
            r_q.flags <= `DSID_FLAGS_RST;
            r_q.cycles <= `DSID_CYC_ONE;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // Outputs straight from the state register
    assign fetch_ready_o = r_q.en && (r_q.st != dsid_pkg::ST_STALL);
    assign reg_rdata_o = r_q.rdata;
    assign dec_valid_o = r_q.valid;
    assign dec_nop_o = r_q.nop;
    assign dec_cycles_o = r_q.cycles;
    assign dec_class_o = r_q.dec.cls;
    assign dec_opcode_o = r_q.dec.opcode;
    assign dec_width_o = r_q.dec.width;
    assign base_reg_operand_o = r_q.dec.base;
    assign source_reg_operand_o = r_q.dec.src;
    assign src_mode_o = r_q.dec.smode;
    assign dest_reg_operand_o = r_q.dec.dst;
    assign dst_mode_o = r_q.dec.dmode;
    assign file_addr_o = r_q.dec.faddr;
    assign to_working_reg_zero_o = r_q.dec.to_wzero;
    assign bit_select_field_o = r_q.dec.bitsel;
    assign bit_indirect_o = r_q.dec.bit_ind;
    assign literal_o = r_q.dec.lit;
    assign acc_b_sel_o = r_q.dec.acc_b;
    assign mul_src_a_o = r_q.dec.mula;
    assign mul_src_b_o = r_q.dec.mulb;
    assign x_prefetch_o = r_q.dec.xpf;
    assign y_prefetch_o = r_q.dec.ypf;
    assign x_dest_o = r_q.dec.xd;
    assign y_dest_o = r_q.dec.yd;
    assign acc_writeback_dest_o = r_q.dec.wbdest;
    assign shift_count_reg_o = r_q.dec.shreg;
    assign shift_by_reg_o = r_q.dec.shby_reg;
    assign program_address_literal_o = r_q.dec.paddr;
    assign status_flags_o = r_q.flags;
    assign error_o = r_q.err;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_run_take;
        take && r_q.st == dsid_pkg::ST_RUN;
    endsequence
    sequence s_skip_taken;
        s_run_take ##0 fetch_word_i[23:20] == 4'h9 && cond_true_i;
    endsequence

    AST_LONE_SECOND: assert property (s_run_take ##0 fetch_word_i[23:16] == 8'h00
        |=> dec_valid_o && dec_class_o == 4'h0 && dec_cycles_o == 2'h1 && !dec_nop_o)
        else $error("lone second word not a one-cycle nop");
    AST_SKIP_TWO_WORD: assert property (s_skip_taken ##0 is_two_word(fetch_next_i[23:16])
        |=> dec_cycles_o == 2'h3 ##1 dec_nop_o [*2] ##1 !dec_nop_o)
        else $error("skip over two-word instruction not three cycles");
    AST_SKIP_ONE_WORD: assert property (s_skip_taken ##0 !is_two_word(fetch_next_i[23:16])
        |=> dec_cycles_o == 2'h2 ##1 dec_nop_o ##1 !dec_nop_o)
        else $error("skip over one-word instruction not two cycles");
    AST_RETURN_THREE: assert property (s_run_take ##0 fetch_word_i[23:20] == 4'hC
        |=> dec_cycles_o == 2'h3 ##1 dec_nop_o [*2])
        else $error("return not three cycles");
    AST_BRANCH_TWO: assert property (s_run_take ##0 fetch_word_i[23:20] == 4'h7
        |=> dec_valid_o && dec_cycles_o == 2'h2 ##1 dec_nop_o ##1 !dec_nop_o)
        else $error("branch not two cycles");
    AST_LONG_PAIR: assert property (s_run_take ##0 is_two_word(fetch_word_i[23:16])
        |=> !dec_valid_o ##0 (r_q.st == dsid_pkg::ST_SECOND))
        else $error("two-word instruction issued before its second word");
    AST_SECOND_HIGH: assert property (take && r_q.st == dsid_pkg::ST_SECOND
        && fetch_word_i[23:16] != 8'h00 |=> error_o[2] && dec_cycles_o == 2'h2)
        else $error("nonzero second word upper byte not flagged");
    AST_ADDR_EVEN: assert property (dec_valid_o && dec_class_o == 4'hE
        |-> program_address_literal_o[0] == 1'b0)
        else $error("program address literal odd");
    AST_FLAG_KEEP: assert property (res_valid_i && r_q.umask == 9'h000 && !reg_wr_i
        |=> $stable(status_flags_o))
        else $error("flags changed by a non-updating class");

endmodule
`default_nettype wire

/* bench/dsid_fetch_model.sv */
// Program memory fetch model that feeds words to the decoder
`timescale 1ns/1ps
`default_nettype none
module dsid_fetch_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fetch handshake toward the decoder
    input wire logic ready_i,
    output logic valid_o,
    output logic [23:0] word_o,
    output logic [23:0] next_o,
    output logic cond_o
);
    // Pending {cond, next, word}
    logic [48:0] q[$];

    // Queue one word, off the rising edge
    task automatic load(input logic [23:0] w, input logic c, input logic [23:0] n);
        q.push_back({c, n, w});
    endtask

    // Retire a taken word, show the head; idle lines toggle
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            valid_o <= 1'b0;
            word_o <= 24'h000000;
            next_o <= 24'h000000;
            cond_o <= 1'b0;
        end
        else
        begin
            if (valid_o && ready_i)
                q.delete(0);
            valid_o <= (q.size() != 0);
            if (q.size() != 0)
            begin
                word_o <= q[0][23:0];
                next_o <= q[0][47:24];
                cond_o <= q[0][48];
            end
            else
            begin
                word_o <= ~word_o;
                next_o <= ~next_o;
                cond_o <= ~cond_o;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/tb_dsc_instruction_decode_timing.sv */
// Self-checking bench for the instruction decode and timing front end
`timescale 1ns/1ps
`default_nettype none
module tb_dsc_instruction_decode_timing;
    // Clock, reset and stimulus
    logic sys_clk_i, sys_rst_i, fetch_valid_i, cond_true_i, res_valid_i, reg_wr_i, reg_rd_i;
    logic [23:0] fetch_word_i, fetch_next_i;
    logic [8:0] res_flags_i;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, literal_o, v;
    // Observed decoder outputs
    logic fetch_ready_o, dec_valid_o, dec_nop_o, to_working_reg_zero_o, bit_indirect_o;
    logic acc_b_sel_o, shift_by_reg_o;
    logic [1:0] dec_cycles_o, dec_width_o, x_dest_o, y_dest_o, acc_writeback_dest_o;
    logic [3:0] dec_class_o, base_reg_operand_o, source_reg_operand_o, dest_reg_operand_o;
    logic [3:0] bit_select_field_o, mul_src_a_o, mul_src_b_o, x_prefetch_o, y_prefetch_o;
    logic [3:0] shift_count_reg_o;
    logic [2:0] dst_mode_o, error_o, src_mode_o;
    logic [7:0] dec_opcode_o;
    logic [12:0] file_addr_o;
    logic [22:0] program_address_literal_o;
    logic [8:0] status_flags_o;
    int err_total, num_checks, cyc_cnt, k;
    logic [7:0] ops[6] = '{8'h70, 8'hA0, 8'hB0, 8'hC0, 8'hD0, 8'h80};
    logic [1:0] cyc[6] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2};

    dsid_decoder dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .fetch_valid_i(fetch_valid_i), .fetch_word_i(fetch_word_i), .fetch_next_i(fetch_next_i),
        .fetch_ready_o(fetch_ready_o), .cond_true_i(cond_true_i), .res_valid_i(res_valid_i),
        .res_flags_i(res_flags_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .dec_valid_o(dec_valid_o), .dec_nop_o(dec_nop_o), .dec_cycles_o(dec_cycles_o),
        .dec_class_o(dec_class_o), .dec_opcode_o(dec_opcode_o), .dec_width_o(dec_width_o),
        .base_reg_operand_o(base_reg_operand_o), .source_reg_operand_o(source_reg_operand_o),
        .src_mode_o(src_mode_o), .dest_reg_operand_o(dest_reg_operand_o), .dst_mode_o(dst_mode_o),
        .file_addr_o(file_addr_o), .to_working_reg_zero_o(to_working_reg_zero_o),
        .bit_select_field_o(bit_select_field_o), .bit_indirect_o(bit_indirect_o),
        .literal_o(literal_o), .acc_b_sel_o(acc_b_sel_o), .mul_src_a_o(mul_src_a_o),
        .mul_src_b_o(mul_src_b_o), .x_prefetch_o(x_prefetch_o), .y_prefetch_o(y_prefetch_o),
        .x_dest_o(x_dest_o), .y_dest_o(y_dest_o), .acc_writeback_dest_o(acc_writeback_dest_o),
        .shift_count_reg_o(shift_count_reg_o), .shift_by_reg_o(shift_by_reg_o),
        .program_address_literal_o(program_address_literal_o),
        .status_flags_o(status_flags_o), .error_o(error_o));

    dsid_fetch_model mem_u (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .ready_i(fetch_ready_o),
        .valid_o(fetch_valid_i), .word_o(fetch_word_i), .next_o(fetch_next_i),
        .cond_o(cond_true_i));

    // Clock of 50 ns period
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Register read; data in the cycle after
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        v = reg_rdata_o;
    endtask

    // Queue a word, await issue, count padding cycles
    task automatic run(input logic [23:0] w, input logic c, input logic [23:0] n,
        input logic [1:0] cy, input logic lw = 1'b0);
        int i;
        int nops;
        nops = 0;
        @(negedge sys_clk_i);
        mem_u.load(w, c, n);
        for (i = 0; i < 12 && dec_valid_o !== 1'b1; i++)
            @(negedge sys_clk_i);
        chk(dec_valid_o, 1);
        chk(dec_cycles_o, cy);
        for (i = 0; i < 4; i++)
        begin
            @(negedge sys_clk_i);
            nops += (dec_nop_o === 1'b1);
        end
        chk(nops, lw ? 0 : cy - 1);
    endtask

    // Counts, verdict, stop
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt >= 3000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // Main sequence
    initial
    begin
        sys_rst_i = 1'b1;
        res_valid_i = 1'b0;
        res_flags_i = 9'h000;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge sys_clk_i);
        chk(fetch_ready_o, 1);
        chk(dec_cycles_o, 1);
        chk(status_flags_o, 0);
        $display("test reset done");
        run(24'h18ABCD, 1'b0, 24'h000000, 2'h1);
        chk(dec_class_o, 4'h1);
        chk(dec_opcode_o, 8'h18);
        chk(dec_width_o, 2'h1);
        chk({base_reg_operand_o, source_reg_operand_o, dst_mode_o, dest_reg_operand_o},
            15'h55ED);
        @(posedge sys_clk_i);
        res_valid_i <= 1'b1;
        res_flags_i <= 9'h1F5;
        @(posedge sys_clk_i);
        res_valid_i <= 1'b0;
        rd(4'h0);
        chk(v, 16'h0015);
        run(24'h203FFF, 1'b0, 24'h000000, 2'h1);
        chk(file_addr_o, 13'h1FFF);
        chk(to_working_reg_zero_o, 1);
        chk(dec_width_o, 2'h0);
        run(24'h305F00, 1'b0, 24'h000000, 2'h1);
        chk({base_reg_operand_o, bit_indirect_o}, 5'h0A);
        chk(bit_select_field_o, 4'hF);
        run(24'h422001, 1'b0, 24'h000000, 2'h1);
        chk(literal_o, 16'hFE00);
        chk(dest_reg_operand_o, 4'h1);
        run(24'h481003, 1'b0, 24'h000000, 2'h1);
        rd(4'h2);
        chk(v[0], 1);
        wr(4'h2, 16'h0007);
        rd(4'h2);
        chk(v[2:0], 3'h0);
        $display("test operand fields done");
        run(24'h51B979, 1'b0, 24'h000000, 2'h1);
        chk({acc_b_sel_o, mul_src_a_o, mul_src_b_o}, 9'h156);
        chk({x_dest_o, y_dest_o, x_prefetch_o, y_prefetch_o}, 12'h979);
        chk({acc_writeback_dest_o, base_reg_operand_o}, 6'h1D);
        run(24'h52B979, 1'b0, 24'h000000, 2'h1);
        chk(acc_writeback_dest_o, 2'h2);
        run(24'h605427, 1'b0, 24'h000000, 2'h1);
        chk({shift_by_reg_o, shift_count_reg_o, src_mode_o, source_reg_operand_o}, 12'hAA7);
        $display("test accumulator fields done");
        for (k = 0; k < 6; k++)
            run({ops[k], 16'h0000}, 1'b1, 24'h000000, cyc[k]);
        run(24'h800000, 1'b0, 24'h000000, 2'h1);
        run(24'h900000, 1'b0, 24'h180000, 2'h1);
        run(24'h900000, 1'b1, 24'h180000, 2'h2);
        run(24'h900000, 1'b1, 24'hE00000, 2'h3);
        $display("test cycle counts done");
        for (k = 0; k < 3; k++)
        begin
            @(negedge sys_clk_i);
            mem_u.load({8'hE0 + k[7:0], 16'h1234}, 1'b0, 24'h000056);
            run(24'h000056, 1'b0, 24'h000000, 2'h2, 1'b1);
            chk(dec_opcode_o, 8'hE0 + k[7:0]);
            chk(program_address_literal_o, {7'h56, 15'h091A, 1'b0});
        end
        run(24'h000056, 1'b0, 24'h000000, 2'h1);
        chk(dec_class_o, 4'h0);
        @(negedge sys_clk_i);
        mem_u.load(24'hE00000, 1'b0, 24'h010000);
        run(24'h010000, 1'b0, 24'h000000, 2'h2, 1'b1);
        rd(4'h2);
        chk({v[2], error_o[2]}, 2'h3);
        $display("test two word done");
        wr(4'h1, 16'h0000);
        @(negedge sys_clk_i);
        chk(fetch_ready_o, 0);
        wr(4'h1, 16'h0001);
        rd(4'hF);
        chk(v, 16'h0000);
        $display("test register port done");
        end_of_test();
    end
endmodule
`default_nettype wire
